// ===== sar_pkg.sv
package sar_pkg;

	localparam int CODE_W = 16;
	localparam int CNT_W = 4;
	localparam int FIFO_DEPTH = 4;
	localparam int SYNC_W = 6;

	// clock period and conversion time bounds
	localparam int CLK_PERIOD_PS = 25000;
	localparam int T_CONV_MIN_NS = 1000;
	localparam int T_CONV_MAX_NS = 1500;
	localparam int CONV_MIN_CYC = (T_CONV_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CONV_MAX_CYC = (T_CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int BIT_CYC = (CONV_MIN_CYC + CODE_W - 1) / CODE_W;
	localparam logic [1:0] STEP_LAST = 2'(BIT_CYC - 1);

	// positions inside the synchroniser bundle
	localparam int SYN_CNV = 0;
	localparam int SYN_SCK = 1;
	localparam int SYN_CHAIN = 2;
	localparam int SYN_EN_IN = 3;
	localparam int SYN_COMP_SEL = 4;
	localparam int SYN_CMP = 5;

	localparam logic [CNT_W-1:0] MSB_IDX = 4'hf;
	localparam logic [CNT_W-1:0] LAST_SHIFT = 4'hf;
	localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
	localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
	localparam logic [CODE_W-1:0] MID_SCALE = 16'h8000;
	localparam logic [CODE_W+1:0] POS_LIMIT = 18'h07fff;
	localparam logic [CODE_W+1:0] NEG_LIMIT = 18'h38000;
	localparam int COMP_SHIFT = 2;

	typedef enum logic [1:0] {st_idle, st_trial, st_push, st_load} conv_state_e;

endpackage

// ===== pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,     // block clock
	input  wire logic             resetn,  // async reset, active low
	input  wire logic [WIDTH-1:0] d_in,    // asynchronous levels
	output logic      [WIDTH-1:0] q_out    // synchronised levels
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// the first stage feeds only the second
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= d_in;
			sync_reg <= meta_reg;
		end
	end

	assign q_out = sync_reg;

endmodule

// ===== data_fifo.sv
`timescale 1ns/10ps
module data_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,        // block clock
	input  wire logic             resetn,     // async reset, active low
	input  wire logic             in_valid,   // write request
	output logic                  in_ready,   // space available
	input  wire logic [WIDTH-1:0] in_data,    // write word
	output logic                  out_valid,  // word available
	input  wire logic             out_ready,  // consumer takes word
	output logic      [WIDTH-1:0] out_data    // head word
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0]   count_reg;
	logic             do_write;
	logic             do_read;

	assign in_ready = (count_reg != (PTR_W+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign do_write = in_valid & in_ready;
	assign do_read = out_valid & out_ready;
	assign out_data = mem[rd_ptr_reg];

	always_ff @(posedge clk)
	begin
		if (do_write)
			mem[wr_ptr_reg] <= in_data;
	end

	// pointers wrap at depth, which need not be a power of two
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (do_write)
				wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			if (do_read)
				rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			if (do_write && !do_read)
				count_reg <= count_reg + 1'b1;
			else if (do_read && !do_write)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule

// ===== sar_adc_serial_readout.sv
`timescale 1ns/10ps
module sar_adc_serial_readout (
	input  wire logic                        clk,                 // 40 MHz block clock
	input  wire logic                        resetn,              // async reset, active low
	input  wire logic                        convert_start,       // convert pin, rising edge starts
	input  wire logic                        sck,                 // host shift clock pin
	input  wire logic                        daisy_select,        // high selects chain mode
	input  wire logic                        enable_or_chain_in,  // enable_n or chain data pin
	input  wire logic                        compression_select,  // low enables compression
	input  wire logic                        comparator_in,       // high: input above dac trial
	output logic                             busy,                // conversion in progress
	output logic [sar_pkg::CODE_W-1:0]       dac_code,            // trial code to the cdac
	output logic                             sdo_out,             // serial data output
	output logic                             sdo_oe               // high while sdo is driven
);

	logic [sar_pkg::SYNC_W-1:0] pins_s;
	logic                       cnv_s;
	logic                       sck_s;
	logic                       chain_s;
	logic                       en_in_s;
	logic                       comp_sel_s;
	logic                       cmp_s;
	logic                       cnv_d_reg;
	logic                       sck_d_reg;
	logic                       cnv_rise;
	logic                       sck_rise;

	sar_pkg::conv_state_e       state_reg;
	logic [sar_pkg::CNT_W-1:0]  bit_idx_reg;
	logic [1:0]                 step_reg;
	logic [sar_pkg::CODE_W-1:0] result_reg;
	logic [sar_pkg::CODE_W-1:0] dac_reg;
	logic                       busy_reg;
	logic [sar_pkg::CODE_W-1:0] bit_mask;
	logic [sar_pkg::CODE_W-1:0] kept_code;

	logic                       fifo_in_valid;
	logic                       fifo_in_ready;
	logic [sar_pkg::CODE_W-1:0] fifo_in_data;
	logic                       fifo_out_valid;
	logic                       fifo_out_ready;
	logic [sar_pkg::CODE_W-1:0] fifo_out_data;

	logic [sar_pkg::CODE_W-1:0] shift_reg;
	logic [sar_pkg::CNT_W-1:0]  shift_cnt_reg;
	logic                       shift_empty_reg;
	logic                       oe_reg;
	logic                       shift_enable;

	// raw offset-binary code to the output code, compressed or not
	function automatic logic [sar_pkg::CODE_W-1:0] map_code(
		input logic [sar_pkg::CODE_W-1:0] raw,
		input logic                       compress
	);
		logic [sar_pkg::CODE_W-1:0] twos;
		logic [sar_pkg::CODE_W+1:0] wide;
		logic [sar_pkg::CODE_W+1:0] scaled;
		logic [sar_pkg::CODE_W+1:0] quarter;
		twos = {~raw[sar_pkg::CODE_W-1], raw[sar_pkg::CODE_W-2:0]};
		wide = {{2{twos[sar_pkg::CODE_W-1]}}, twos};
		// the quarter must keep the sign, so the shift runs on a signed operand alone
		quarter = $signed(wide) >>> sar_pkg::COMP_SHIFT;
		scaled = wide + quarter;
		if (!compress)
			map_code = twos;
		else if (!scaled[sar_pkg::CODE_W+1] && scaled > sar_pkg::POS_LIMIT)
			map_code = sar_pkg::POS_LIMIT[sar_pkg::CODE_W-1:0];
		else if (scaled[sar_pkg::CODE_W+1] && scaled < sar_pkg::NEG_LIMIT)
			map_code = sar_pkg::NEG_LIMIT[sar_pkg::CODE_W-1:0];
		else
			map_code = scaled[sar_pkg::CODE_W-1:0];
	endfunction

	// every input but clk and resetn, the shift clock and the comparator included, crosses in two flops
	pin_sync #(
		.WIDTH (sar_pkg::SYNC_W)
	) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.d_in   ({comparator_in, compression_select, enable_or_chain_in,
			daisy_select, sck, convert_start}),
		.q_out  (pins_s)
	);

	assign cnv_s = pins_s[sar_pkg::SYN_CNV];
	assign sck_s = pins_s[sar_pkg::SYN_SCK];
	assign chain_s = pins_s[sar_pkg::SYN_CHAIN];
	assign en_in_s = pins_s[sar_pkg::SYN_EN_IN];
	assign comp_sel_s = pins_s[sar_pkg::SYN_COMP_SEL];
	assign cmp_s = pins_s[sar_pkg::SYN_CMP];

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnv_d_reg <= 1'b0;
			sck_d_reg <= 1'b0;
		end
		else
		begin
			cnv_d_reg <= cnv_s;
			sck_d_reg <= sck_s;
		end
	end

	assign cnv_rise = cnv_s & ~cnv_d_reg;
	assign sck_rise = sck_s & ~sck_d_reg;

	assign bit_mask = sar_pkg::MID_SCALE >> (sar_pkg::MSB_IDX - bit_idx_reg);
	assign kept_code = cmp_s ? dac_reg : (dac_reg & ~bit_mask);

	// conversion sequencer: each bit gets BIT_CYC cycles so the comparator
	// answer has crossed the synchroniser before it is judged
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= sar_pkg::st_idle;
			bit_idx_reg <= sar_pkg::MSB_IDX;
			step_reg <= 2'h0;
			result_reg <= sar_pkg::CODE_RESET;
			dac_reg <= sar_pkg::CODE_RESET;
			busy_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				sar_pkg::st_idle:
				begin
					if (cnv_rise)
					begin
						state_reg <= sar_pkg::st_trial;
						bit_idx_reg <= sar_pkg::MSB_IDX;
						step_reg <= 2'h0;
						dac_reg <= sar_pkg::MID_SCALE;
						busy_reg <= 1'b1;
					end
				end
				sar_pkg::st_trial:
				begin
					if (step_reg != sar_pkg::STEP_LAST)
						step_reg <= step_reg + 2'h1;
					else
					begin
						step_reg <= 2'h0;
						if (bit_idx_reg == sar_pkg::CNT_RESET)
						begin
							result_reg <= map_code(kept_code, ~comp_sel_s);
							dac_reg <= kept_code;
							state_reg <= sar_pkg::st_push;
						end
						else
						begin
							dac_reg <= kept_code | (bit_mask >> 1);
							bit_idx_reg <= bit_idx_reg - 4'h1;
						end
					end
				end
				sar_pkg::st_push:
				begin
					// a full buffer holds the sequencer here
					if (fifo_in_ready)
						state_reg <= sar_pkg::st_load;
				end
				sar_pkg::st_load:
				begin
					if (!fifo_out_valid && !shift_empty_reg)
					begin
						state_reg <= sar_pkg::st_idle;
						busy_reg <= 1'b0;
					end
				end
				default:
				begin
					state_reg <= sar_pkg::st_idle;
					busy_reg <= 1'b0;
				end
			endcase
		end
	end

	assign fifo_in_valid = (state_reg == sar_pkg::st_push);
	assign fifo_in_data = result_reg;
	// while busy the shifter swallows anything queued, so the last word
	// popped before busy falls is always the fresh result
	assign fifo_out_ready = shift_empty_reg | busy_reg;

	data_fifo #(
		.WIDTH (sar_pkg::CODE_W),
		.DEPTH (sar_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	assign shift_enable = chain_s | ~en_in_s;

	// output shifter; host edges during a conversion are ignored
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			shift_reg <= sar_pkg::CODE_RESET;
			shift_cnt_reg <= sar_pkg::CNT_RESET;
			shift_empty_reg <= 1'b1;
		end
		else if (fifo_out_valid && fifo_out_ready)
		begin
			shift_reg <= fifo_out_data;
			shift_cnt_reg <= sar_pkg::CNT_RESET;
			shift_empty_reg <= 1'b0;
		end
		else if (cnv_rise && state_reg == sar_pkg::st_idle)
			shift_empty_reg <= 1'b1;
		else if (sck_rise && shift_enable && !busy_reg)
		begin
			shift_reg <= {shift_reg[sar_pkg::CODE_W-2:0], chain_s & en_in_s};
			shift_cnt_reg <= shift_cnt_reg + 4'h1;
			// chain mode keeps the shifter as a pass-through of upstream data
			if (!chain_s && shift_cnt_reg == sar_pkg::LAST_SHIFT)
				shift_empty_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			oe_reg <= 1'b0;
		else
			oe_reg <= shift_enable;
	end

	assign sdo_out = shift_reg[sar_pkg::CODE_W-1];
	assign sdo_oe = oe_reg;
	assign busy = busy_reg;
	assign dac_code = dac_reg;

endmodule

// ===== sar_checker_asserts.sv
`timescale 1ns/10ps
module sar_checker (
	input wire logic                        clk,                // block clock
	input wire logic                        resetn,             // async reset
	input wire logic                        convert_start,      // convert pin
	input wire logic                        sck,                // shift clock pin
	input wire logic                        daisy_select,       // chain mode select
	input wire logic                        enable_or_chain_in, // enable or chain data
	input wire logic                        compression_select, // compression select
	input wire logic                        comparator_in,      // comparator level
	input wire logic                        busy,               // conversion flag
	input wire logic [sar_pkg::CODE_W-1:0]  dac_code,           // trial code
	input wire logic                        sdo_out,            // serial data
	input wire logic                        sdo_oe              // output enable
);
	logic [7:0] busy_cnt;
	logic [7:0] since_cnv;
	logic [7:0] since_sck;
	logic       cnv_q;
	logic       sck_q;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// saturating ages so long idle stretches never wrap back into the window
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy_cnt <= 8'h00;
			since_cnv <= 8'hff;
			since_sck <= 8'hff;
			cnv_q <= 1'b0;
			sck_q <= 1'b0;
		end
		else
		begin
			busy_cnt <= busy ? busy_cnt + 8'h01 : 8'h00;
			cnv_q <= convert_start;
			sck_q <= sck;
			since_cnv <= (convert_start && !cnv_q) ? 8'h00 : since_cnv + {7'h00, since_cnv != 8'hff};
			since_sck <= (sck && !sck_q) ? 8'h00 : since_sck + {7'h00, since_sck != 8'hff};
		end
	end

	sequence s_cnv_edge;
		$rose(convert_start) && !busy;
	endsequence
	sequence s_busy_done;
		$fell(busy);
	endsequence

	property p_busy_start;
		s_cnv_edge |-> ##[1:5] busy;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy missed a convert edge");
	property p_conv_time;
		s_busy_done |-> busy_cnt >= 8'(sar_pkg::CONV_MIN_CYC) && busy_cnt <= 8'(sar_pkg::CONV_MAX_CYC);
	endproperty
	a_conv_time: assert property (p_conv_time) else $error("conversion length out of range");
	property p_busy_cause;
		$rose(busy) |-> since_cnv <= 8'h06;
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy rose without convert");
	property p_dac_mid;
		$rose(busy) |-> ##[0:2] dac_code == sar_pkg::MID_SCALE;
	endproperty
	a_dac_mid: assert property (p_dac_mid) else $error("first trial not mid scale");
	property p_dac_idle;
		!busy ##1 !busy |-> $stable(dac_code);
	endproperty
	a_dac_idle: assert property (p_dac_idle) else $error("trial code moved while idle");
	property p_oe_off;
		(!daisy_select && enable_or_chain_in) [*5] |-> !sdo_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output not released");
	property p_oe_on;
		(!daisy_select && !enable_or_chain_in) [*5] |-> sdo_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("output not driven");
	property p_oe_chain;
		daisy_select [*5] |-> sdo_oe;
	endproperty
	a_oe_chain: assert property (p_oe_chain) else $error("output off in chain mode");
	property p_sdo_quiet;
		$changed(sdo_out) |-> busy || $fell(busy) || since_sck <= 8'h05 || since_cnv <= 8'h06;
	endproperty
	a_sdo_quiet: assert property (p_sdo_quiet) else $error("sdo moved without a shift");
endmodule

bind sar_adc_serial_readout sar_checker chk (
	.clk                (clk),
	.resetn             (resetn),
	.convert_start      (convert_start),
	.sck                (sck),
	.daisy_select       (daisy_select),
	.enable_or_chain_in (enable_or_chain_in),
	.compression_select (compression_select),
	.comparator_in      (comparator_in),
	.busy               (busy),
	.dac_code           (dac_code),
	.sdo_out            (sdo_out),
	.sdo_oe             (sdo_oe)
);

// ===== host_model.sv
`timescale 1ns/10ps
module host_model (
	input  wire logic                       clk,                // block clock
	input  wire logic                       busy,               // conversion flag
	input  wire logic [sar_pkg::CODE_W-1:0] dac_code,           // trial code
	input  wire logic                       sdo_out,            // serial data
	output logic                            convert_start,      // convert pin
	output logic                            sck,                // shift clock
	output logic                            enable_or_chain_in, // enable or chain data
	output logic                            comparator_in       // comparator level
);
	logic [15:0] analog;

	// a trial equal to the input counts as below it, so the result lands on analog
	assign comparator_in = (dac_code <= analog);

	initial
	begin
		convert_start = 1'b0;
		sck = 1'b0;
		enable_or_chain_in = 1'b0;
		analog = 16'h8000;
	end

	task pulse;
		@(negedge clk);
		convert_start = 1'b1;
		repeat (2) @(negedge clk);
		convert_start = 1'b0;
	endtask

	task convert(output bit ok);
		pulse();
		repeat (4) @(negedge clk);
		ok = 1'b0;
		for (int i = 0; i < 100 && !ok; i++)
		begin
			@(negedge clk);
			ok = (busy === 1'b0);
		end
	endtask

	// shift clock idles low between frames
	task shift(input int n, input logic [31:0] up, output logic [31:0] got);
		got = 32'h0;
		for (int i = n - 1; i >= 0; i--)
		begin
			@(negedge clk);
			sck = 1'b0;
			enable_or_chain_in = up[i];
			repeat (3) @(negedge clk);
			got[i] = sdo_out;
			@(negedge clk);
			sck = 1'b1;
			repeat (3) @(negedge clk);
		end
		@(negedge clk);
		sck = 1'b0;
	endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic        clk;
	logic        resetn;
	logic        daisy_select;
	logic        compression_select;
	wire         convert_start;
	wire         sck;
	wire         enable_or_chain_in;
	wire         comparator_in;
	wire         busy;
	wire         sdo_out;
	wire         sdo_oe;
	wire  [15:0] dac_code;
	int          errors;
	int          check_count;
	logic [31:0] g;
	logic [15:0] e;
	logic [15:0] v[6] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff, 16'h1234, 16'hc001};
	logic [15:0] w[4] = '{16'hffff, 16'h0000, 16'ha000, 16'h6000};
	bit          ok;

	sar_adc_serial_readout uut (.clk(clk), .resetn(resetn), .convert_start(convert_start),
		.sck(sck), .daisy_select(daisy_select), .enable_or_chain_in(enable_or_chain_in),
		.compression_select(compression_select), .comparator_in(comparator_in), .busy(busy),
		.dac_code(dac_code), .sdo_out(sdo_out), .sdo_oe(sdo_oe));
	host_model host (.clk(clk), .busy(busy), .dac_code(dac_code), .sdo_out(sdo_out),
		.convert_start(convert_start), .sck(sck), .enable_or_chain_in(enable_or_chain_in),
		.comparator_in(comparator_in));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task final_report;
		if (errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// compression scales by 1.25 about zero and clips at the code limits
	function automatic logic [15:0] exp_code(input logic [15:0] a, input logic comp);
		logic signed [17:0] r;
		r = {{3{~a[15]}}, a[14:0]};
		if (comp)
			r = r + (r >>> 2);
		if (r > 32767)
			r = 18'sh07fff;
		else if (r < -32768)
			r = -18'sh08000;
		return r[15:0];
	endfunction

	task run_conv(input logic [15:0] a, input logic comp);
		@(negedge clk);
		host.analog = a;
		compression_select = ~comp;
		repeat (4) @(negedge clk);
		host.convert(ok);
		if (!ok)
		begin
			errors++;
			final_report();
		end
		e = exp_code(a, comp);
		chk({31'h0, sdo_out}, {31'h0, e[15]});
	endtask

	task t_normal;
		foreach (v[i])
		begin
			run_conv(v[i], 1'b0);
			host.shift(16, 32'h0, g);
			chk(g, {16'h0, e});
		end
	endtask

	task t_comp;
		foreach (w[i])
		begin
			run_conv(w[i], 1'b1);
			host.shift(16, 32'h0, g);
			chk(g, {16'h0, e});
		end
	endtask

	task t_busy_edge;
		compression_select = 1'b1;
		host.analog = 16'h4321;
		host.pulse();
		repeat (12) @(negedge clk);
		host.convert(ok);
		if (!ok)
		begin
			errors++;
			final_report();
		end
		repeat (6) @(negedge clk);
		chk({31'h0, busy}, 32'h0);
		host.shift(16, 32'h0, g);
		chk(g, {16'h0, exp_code(16'h4321, 1'b0)});
	endtask

	task t_enable;
		run_conv(16'h2468, 1'b0);
		host.enable_or_chain_in = 1'b1;
		repeat (6) @(negedge clk);
		chk({31'h0, sdo_oe}, 32'h0);
		host.shift(4, 32'hf, g);
		host.enable_or_chain_in = 1'b0;
		repeat (6) @(negedge clk);
		chk({31'h0, sdo_oe}, 32'h1);
		host.shift(16, 32'h0, g);
		chk(g, {16'h0, e});
	endtask

	task t_chain;
		daisy_select = 1'b1;
		run_conv(16'h9abc, 1'b0);
		host.shift(32, {16'h5a3c, 16'h0}, g);
		chk(g, {e, 16'h5a3c});
		chk({31'h0, sdo_oe}, 32'h1);
		daisy_select = 1'b0;
	endtask

	initial
	begin
		resetn = 1'b0;
		daisy_select = 1'b0;
		compression_select = 1'b1;
		errors = 0;
		check_count = 0;
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		t_normal();
		t_comp();
		t_busy_edge();
		t_enable();
		t_chain();
		final_report();
	end
endmodule
